// ==== common/wsc_pkg.sv ====
package wsc_pkg;
    // Link-side state reported by the radio core
    typedef enum logic [4:0] {
        WSC_IDLE     = 5'b00001,
        WSC_SCAN     = 5'b00010,
        WSC_ASSOC    = 5'b00100,
        WSC_ADHOC    = 5'b01000,
        WSC_OTHER    = 5'b10000
    } wsc_net_e;
    localparam int WSC_WORD_W = 8;
    localparam int WSC_CLK_HZ = 100_000_000;
    localparam int WSC_BLINK_MS = 250;
    localparam int WSC_BLINK_CYC = WSC_CLK_HZ / 1000 * WSC_BLINK_MS;
    localparam logic WSC_SO_RST = 1'b1;
    localparam logic WSC_LED_RST = 1'b0;
endpackage

// ==== common/wsc_sync_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface wsc_sync_if;
    logic cs_n;
    logic sck;
    logic si;
    logic rst_n;
    modport src (output cs_n, output sck, output si, output rst_n);
    modport dst (input cs_n, input sck, input si, input rst_n);
endinterface
`default_nettype wire

// ==== design/wsc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for the four pin inputs
module wsc_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Raw pins
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic pin_rst_n_i,
    // Synchronised levels
    wsc_sync_if.src out
);
    logic [3:0] meta;
    logic [3:0] stab;
    logic [3:0] next_meta;
    logic [3:0] next_stab;

    always_comb begin
        next_meta = {pin_rst_n_i, si_i, sck_i, cs_n_i};
        next_stab = meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 4'hb;
            stab <= 4'hb;
        end else begin
            meta <= next_meta;
            stab <= next_stab;
        end
    end

    assign out.cs_n = stab[0];
    assign out.sck = stab[1];
    assign out.si = stab[2];
    assign out.rst_n = stab[3];
endmodule // wsc_sync
`default_nettype wire

// ==== design/wsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: The host selects the module by driving chip select low and deselects it by driving it high.
// R2: The module is held in reset while its reset input is low and runs when it is high.
// R3: Host output feeds the module serial input and the module serial output feeds the host.
// R4: The host configures its pin directions itself before use.
// R5: The host application, not the transfer logic, produces the module hardware reset.
// R6: With derived reset, reset is active whenever chip select is high and clock is low.
// R7: In normal traffic the host never holds clock low while chip select is high.
// R8: A host with two-way pins may share one data line and turn it around between phases.
// R9: The red indicator blinks while a host-requested scan runs.
// R10: The indicator is steadily lit while associated with an access point.
// R11: The indicator is steadily lit in peer-to-peer mode with at least one peer connected.
// R12: The indicator is off in every other state.
// R13: The module is only a slave and never originates transfers or drives the clock.
// R14: The host keeps chip select low over a transaction and returns clock high before ending it.
module wsc_top #(
    parameter int WORD_W = wsc_pkg::WSC_WORD_W,
    parameter int BLINK_CYC = wsc_pkg::WSC_BLINK_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Link pins from the host
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic serial_in_line_i,
    input wire logic pin_rst_n_i,
    // Link pin to the host
    output logic so_o,
    output logic so_oe_n_o,
    // Radio core side
    input wire wsc_pkg::wsc_net_e net_state_i,
    input wire logic peer_present_i,
    input wire logic [WORD_W-1:0] tx_word_i,
    output logic tx_load_o,
    output logic [WORD_W-1:0] rx_word_o,
    output logic rx_valid_o,
    output logic core_rst_n_o,
    // Status indicator
    output logic led_o
);
    import wsc_pkg::*;

    wsc_sync_if pins ();

    wsc_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .cs_n_i(cs_n_i),
        .sck_i(sck_i),
        .si_i(serial_in_line_i),
        .pin_rst_n_i(pin_rst_n_i),
        .out(pins)
    );

    localparam int CNT_W = $clog2(WORD_W + 1);
    localparam int BL_W = $clog2(BLINK_CYC + 1);

    logic sck_d;
    logic next_sck_d;
    logic [WORD_W-1:0] shreg;
    logic [WORD_W-1:0] next_shreg;
    logic [CNT_W-1:0] bits;
    logic [CNT_W-1:0] next_bits;
    logic [WORD_W-1:0] rx_word;
    logic [WORD_W-1:0] next_rx_word;
    logic rx_valid;
    logic next_rx_valid;
    logic so;
    logic next_so;
    logic load_pend;
    logic next_load_pend;
    logic [BL_W-1:0] blink_cnt;
    logic [BL_W-1:0] next_blink_cnt;
    logic blink;
    logic next_blink;
    logic led;
    logic next_led;
    logic link_rst;
    logic rise;
    logic fall;
    logic sel;

    // Frame tracking; after any reset a frame is only joined from a clean deselect
    typedef enum logic [2:0] {
        WSC_LNK_HELD = 3'b001,
        WSC_LNK_IDLE = 3'b010,
        WSC_LNK_BUSY = 3'b100
    } wsc_link_e;
    wsc_link_e lstate;
    wsc_link_e next_lstate;

    // Derived reset from the SPI lines, or the dedicated pin
    assign link_rst = (pins.cs_n && !pins.sck) || !pins.rst_n; // R6 R2 R5
    assign sel = lstate == WSC_LNK_BUSY && !pins.cs_n && !link_rst; // R1
    assign rise = sel && pins.sck && !sck_d;
    assign fall = sel && !pins.sck && sck_d;

    always_comb begin
        next_lstate = lstate;
        case (lstate)
            WSC_LNK_HELD: begin
                // Released with the host still mid-frame: wait for deselect
                if (!link_rst && pins.cs_n) begin
                    next_lstate = WSC_LNK_IDLE;
                end
            end
            WSC_LNK_IDLE: begin
                if (link_rst) begin
                    next_lstate = WSC_LNK_HELD;
                end else if (!pins.cs_n) begin
                    next_lstate = WSC_LNK_BUSY; // R1
                end
            end
            WSC_LNK_BUSY: begin
                if (link_rst) begin
                    next_lstate = WSC_LNK_HELD;
                end else if (pins.cs_n) begin
                    next_lstate = WSC_LNK_IDLE;
                end
            end
            default: begin
                next_lstate = WSC_LNK_HELD;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lstate <= WSC_LNK_HELD;
        end else begin
            lstate <= next_lstate;
        end
    end

    always_comb begin
        next_sck_d = pins.sck;
        next_shreg = shreg;
        next_bits = bits;
        next_rx_word = rx_word;
        next_rx_valid = 1'b0;
        next_so = so;
        next_load_pend = 1'b0;
        if (!sel) begin
            // Frame ends: drop partial word, reload for next frame
            next_bits = '0;
            next_shreg = tx_word_i;
            next_so = tx_word_i[WORD_W-1];
        end else if (rise) begin
            // Sample the host's data on rising clock
            next_shreg = {shreg[WORD_W-2:0], pins.si}; // R3
            if (bits == CNT_W'(WORD_W - 1)) begin
                next_bits = '0;
                next_rx_word = {shreg[WORD_W-2:0], pins.si};
                next_rx_valid = 1'b1;
                next_load_pend = 1'b1;
            end else begin
                next_bits = bits + CNT_W'(1);
            end
        end else if (load_pend) begin
            next_shreg = tx_word_i;
        end else if (fall) begin
            // Shift out on the falling clock only; the host owns the clock
            next_so = shreg[WORD_W-1]; // R13 R3
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_d <= 1'b1;
            shreg <= '0;
            bits <= '0;
            rx_word <= '0;
            rx_valid <= 1'b0;
            so <= WSC_SO_RST;
            load_pend <= 1'b0;
        end else begin
            sck_d <= next_sck_d;
            shreg <= next_shreg;
            bits <= next_bits;
            rx_word <= next_rx_word;
            rx_valid <= next_rx_valid;
            so <= next_so;
            load_pend <= next_load_pend;
        end
    end

    // Indicator
    always_comb begin
        next_blink_cnt = blink_cnt;
        next_blink = blink;
        next_led = WSC_LED_RST;
        if (link_rst || net_state_i != WSC_SCAN) begin
            next_blink_cnt = '0;
            next_blink = 1'b1;
        end else if (blink_cnt == BL_W'(BLINK_CYC - 1)) begin
            next_blink_cnt = '0;
            next_blink = !blink;
        end else begin
            next_blink_cnt = blink_cnt + BL_W'(1);
        end
        if (!link_rst) begin
            case (net_state_i)
                WSC_SCAN: next_led = blink; // R9
                WSC_ASSOC: next_led = 1'b1; // R10
                WSC_ADHOC: next_led = peer_present_i; // R11
                default: next_led = 1'b0; // R12
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blink_cnt <= '0;
            blink <= 1'b1;
            led <= WSC_LED_RST;
        end else begin
            blink_cnt <= next_blink_cnt;
            blink <= next_blink;
            led <= next_led;
        end
    end

    assign so_o = so;
    // Release the output while deselected so a shared line can turn round
    assign so_oe_n_o = !sel; // R8
    // Word is taken while deselected and one cycle after each word end
    assign tx_load_o = load_pend || !sel;
    assign rx_word_o = rx_word;
    assign rx_valid_o = rx_valid;
    assign core_rst_n_o = !link_rst;
    assign led_o = led;
endmodule // wsc_top
`default_nettype wire

// ==== tb/wsc_top_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module wsc_top_asserts import wsc_pkg::*; #(
    parameter int BLINK_CYC = 4
) (
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire wsc_pkg::wsc_net_e net_state_i,
    input wire logic peer_present_i,
    input wire logic so_oe_n_o,
    input wire logic rx_valid_o,
    input wire logic led_o
);
    localparam int BW = BLINK_CYC + 2;
    logic pair;
    assign pair = net_state_i == WSC_ADHOC && peer_present_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_BLINK: assert property ((net_state_i == WSC_SCAN) [*4] |-> ##[1:BW]
        ($changed(led_o) || net_state_i != WSC_SCAN)) else $error("no blink");
    AST_ASSOC: assert property ((net_state_i == WSC_ASSOC) [*3] |-> led_o)
        else $error("assoc dark");
    AST_PEER: assert property (pair [*3] |-> led_o)
        else $error("peer dark");
    AST_DARK: assert property ((net_state_i != WSC_SCAN && net_state_i != WSC_ASSOC
        && !pair) [*3] |-> !led_o) else $error("led lit");
    AST_SLAVE: assert property (cs_n_i [*4] |-> so_oe_n_o && !rx_valid_o)
        else $error("active unselected");
endmodule // wsc_top_asserts
bind wsc_top wsc_top_asserts #(.BLINK_CYC(BLINK_CYC)) u_chk (.clk_i, .rst_n_i, .cs_n_i,
    .net_state_i, .peer_present_i, .so_oe_n_o, .rx_valid_o, .led_o);
`default_nettype wire

// ==== tb/wsc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module wsc_host_model (
    // From module
    input wire logic so_i,
    input wire logic so_oe_n_i,
    // To module
    output logic cs_n_o,
    output logic sck_o,
    output logic mosi_o,
    output logic pin_rst_n_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b1;
        mosi_o = 1'b1;
        pin_rst_n_o = 1'b1;
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        cs_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #80 sck_o = 1'b0;
            mosi_o = tx[i];
            #80 sck_o = 1'b1;
            rx[i] = so_oe_n_i ? ~so_i : so_i;
        end
        #80 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask
    task automatic rst_req(input logic derived, input logic on);
        if (derived) sck_o = ~on;
        else pin_rst_n_o = ~on;
    endtask
endmodule // wsc_host_model
`default_nettype wire

// ==== tb/tb_wsc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_wsc_top;
    import wsc_pkg::*;
    logic clk, rst_n, peer, rx_v, so, oe_n, crst_n, led, cs_n, sck, mosi, prst_n, tx_ld;
    wsc_net_e st;
    logic [7:0] txw, rxw, got, hrx;
    int n_mismatch = 0;
    int num_checks = 0;
    wsc_top #(.BLINK_CYC(4)) u_dut (.clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n),
        .sck_i(sck), .serial_in_line_i(mosi), .pin_rst_n_i(prst_n), .so_o(so),
        .so_oe_n_o(oe_n), .net_state_i(st), .peer_present_i(peer), .tx_word_i(txw),
        .tx_load_o(tx_ld), .rx_word_o(rxw), .rx_valid_o(rx_v), .core_rst_n_o(crst_n),
        .led_o(led));
    wsc_host_model u_host (.so_i(so), .so_oe_n_i(oe_n), .cs_n_o(cs_n), .sck_o(sck),
        .mosi_o(mosi), .pin_rst_n_o(prst_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) if (rx_v === 1'b1) got <= rxw;
    task automatic t_link;
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            txw = i ? 8'h81 : 8'ha5;
            got = 8'h00;
            u_host.xfer(8'h3c ^ txw, hrx);
            repeat (6) @(negedge clk);
            chk(got, 8'h3c ^ txw);
            chk(hrx, txw);
        end
        chk({7'h0, oe_n}, 8'h01);
        chk({7'h0, tx_ld}, 8'h01);
    endtask
    task automatic t_rst;
        for (int d = 0; d < 2; d++) begin
            u_host.rst_req(d[0], 1'b1);
            repeat (4) @(negedge clk);
            chk({7'h0, crst_n}, 8'h00);
            u_host.rst_req(d[0], 1'b0);
            repeat (4) @(negedge clk);
            chk({7'h0, crst_n}, 8'h01);
        end
    endtask
    task automatic t_led;
        wsc_net_e s[5] = '{WSC_IDLE, WSC_ASSOC, WSC_ADHOC, WSC_ADHOC, WSC_OTHER};
        logic [4:0] e = 5'b00110;
        logic [7:0] tog = 8'h00;
        logic p;
        st = WSC_SCAN;
        p = led;
        repeat (20) begin
            @(negedge clk);
            if (led !== p) tog++;
            p = led;
        end
        chk({7'h0, tog > 8'h02}, 8'h01);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk);
            st = s[i];
            peer = (i == 2);
            repeat (4) @(negedge clk);
            chk({7'h0, led}, {7'h0, e[i]});
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        st = WSC_IDLE;
        peer = 1'b0;
        txw = 8'h00;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_link();
        t_rst();
        t_led();
        stop_test();
    end
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule // tb_wsc_top
`default_nettype wire
